// [hdl/dmc_pkg.sv]
// Package: register indices, field positions, reset values of non-strapped bits and timing for the DRAM map block
package dmc_pkg;
	// Register indices behind the data port
	localparam logic [7:0] DMC_DATA_PORT    = 8'hed;
	localparam logic [7:0] DMC_IDX_MAP      = 8'h03;
	localparam logic [7:0] DMC_IDX_CTRL     = 8'h05;
	// Map register fields
	localparam int         DMC_MAP_LARGE    = 7;
	localparam int         DMC_MAP_ROM_HI   = 6;
	localparam int         DMC_MAP_ROM_LO   = 5;
	localparam int         DMC_MAP_REMAP    = 4;
	localparam int         DMC_MAP_CODE_LSB = 0;
	localparam int         DMC_MAP_CODE_W   = 4;
	// Control register fields
	localparam int         DMC_CTL_WAKE     = 7;
	localparam int         DMC_CTL_DELAY    = 6;
	// Reset values of non-strapped bits
	localparam logic       DMC_RST_LARGE    = 1'b0;
	localparam logic       DMC_RST_WAKE     = 1'b0;
	localparam logic       DMC_RST_DELAY    = 1'b0;
	localparam logic [5:0] DMC_RST_CTL_LOW  = 6'h00;
	// Start delay in double-rate clock periods
	localparam int         DMC_START_DLY    = 2;
	// Memory boundaries in 64 KB units
	localparam logic [7:0] DMC_VID_ROM_SEG  = 8'h0c;
	localparam logic [7:0] DMC_SYS_ROM_SEG  = 8'h0e;
	localparam logic [7:0] DMC_REMAP_SIZE   = 8'h06;
	localparam logic [7:0] DMC_REMAP_BASE   = 8'h0a;
	// Cycle start states
	typedef enum logic [2:0] {
		DMC_ST_IDLE = 3'b001,
		DMC_ST_WAIT = 3'b010,
		DMC_ST_GO   = 3'b100
	} dmc_start_e;
endpackage

// [hdl/dmc_start_delay.sv]
// Cycle start delay: optional two double-rate clock delay after the address strobe
`timescale 1ns/1ps
module dmc_start_delay
	import dmc_pkg::*;
#(
	parameter int DELAY_TICKS = DMC_START_DLY
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Control
	input  wire logic dbl_clk_en,
	input  wire logic delay_on,
	input  wire logic mem_read_miss,
	input  wire logic strobe_rise,
	// Result
	output logic      cycle_start
);
	// The down counter is three bits wide, so longer delays cannot be served
	if (DELAY_TICKS < 1 || DELAY_TICKS > 7) begin : dly_range_bad
		$error("DELAY_TICKS out of range");
	end

	dmc_start_e state_reg;
	dmc_start_e state_next;
	logic [2:0] count_reg;
	logic [2:0] count_next;
	logic       start_reg;
	logic       start_next;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		start_next = 1'b0;
		case (state_reg)
			DMC_ST_IDLE: begin
				if (strobe_rise) begin
					if (delay_on && mem_read_miss) begin
						state_next = DMC_ST_WAIT;
						count_next = 3'(DELAY_TICKS);
					end else begin
						start_next = 1'b1;
					end
				end
			end
			DMC_ST_WAIT: begin
				if (dbl_clk_en) begin
					count_next = count_reg - 3'h1;
					if (count_reg == 3'h1) begin
						state_next = DMC_ST_GO;
					end
				end
			end
			DMC_ST_GO: begin
				start_next = 1'b1;
				state_next = DMC_ST_IDLE;
			end
			default: state_next = DMC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= DMC_ST_IDLE;
			count_reg <= 3'h0;
			start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			start_reg <= start_next;
		end
	end

	assign cycle_start = start_reg;
endmodule

// [hdl/dmc_dram_map_regs.sv]
// DRAM map and control configuration registers with decode outputs
//
// Overview of operation
// - Large-bank bit set means 512Kx8 parts fitted
// - ROM move bits relocate video and system ROM
// - ROM move bits load from straps 8, 7
// - Remap bit moves 384K above map top
// - Remap honoured only for 1M-4M totals
// - Remap bit loads from strap 4
// - Four-bit map code selects decoding configuration
// - Map code loads from low straps
// - Cache-enable and wake bit select pin role
// - Wake output low during DMA and master cycles
// - Setting cache-enable clears the wake bit
// - Delay bit postpones start two double-rate clocks
// - Delay only on read cache-miss cycles
// - Delay bit resets to zero
`timescale 1ns/1ps
module dmc_dram_map_regs
	import dmc_pkg::*;
#(
	parameter int CLK_DIV = 2
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Strap lines sampled as reset releases
	input  wire logic       strap_line_8,
	input  wire logic       strap_line_7,
	input  wire logic       strap_line_4,
	input  wire logic [3:0] strap_lines_low,
	// Configuration port access
	input  wire logic       idx_wr,
	input  wire logic       data_wr,
	input  wire logic       data_rd,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	// Miscellaneous register cache-enable bit and its write strobe
	input  wire logic       cache_feature_on,
	input  wire logic       cache_feature_set,
	// Installed memory in megabytes
	input  wire logic [4:0] total_mem_mb,
	// Cycle information
	input  wire logic       dma_or_master,
	input  wire logic       addr_strobe_rise,
	input  wire logic       mem_read_miss,
	// Address decode
	input  wire logic [7:0] addr_seg,
	output logic            rom_on_board,
	output logic            rom_to_slot,
	output logic [7:0]      remap_seg,
	output logic            remap_hit,
	// Configuration outputs
	output logic            large_bank_option,
	output logic [3:0]      memory_map_code,
	output logic            remap_active,
	// Shared wake / miss pin
	output logic            wake_out,
	output logic            wake_oe,
	output logic            cycle_start
);
	import dmc_pkg::*;

	// The divider counts in eight bits
	if (CLK_DIV < 1 || CLK_DIV > 255) begin : div_range_bad
		$error("CLK_DIV out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] index_reg;
	logic [7:0] index_next;
	logic [7:0] map_reg;
	logic [7:0] map_next;
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic       strap_pend_reg;
	logic       strap_pend_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;

	// Straps are caught on the first clock after reset, never under it
	always_comb begin
		index_next      = index_reg;
		map_next        = map_reg;
		ctl_next        = ctl_reg;
		strap_pend_next = 1'b0;
		rd_next         = rd_reg;
		if (strap_pend_reg) begin
			map_next[DMC_MAP_ROM_HI] = strap_line_8;
			map_next[DMC_MAP_ROM_LO] = strap_line_7;
			map_next[DMC_MAP_REMAP]  = strap_line_4;
			map_next[DMC_MAP_CODE_LSB +: DMC_MAP_CODE_W] = strap_lines_low;
		end
		if (idx_wr) begin
			index_next = wr_data;
		end
		if (data_wr) begin
			if (index_reg == DMC_IDX_MAP) begin
				map_next = wr_data;
			end else if (index_reg == DMC_IDX_CTRL) begin
				ctl_next = wr_data;
			end
		end
		// Cache-enable write wins over a simultaneous wake write
		if (cache_feature_set) begin
			ctl_next[DMC_CTL_WAKE] = 1'b0;
		end
		if (data_rd) begin
			case (index_reg)
				DMC_IDX_MAP:  rd_next = map_reg;
				DMC_IDX_CTRL: rd_next = ctl_reg;
				default:      rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			index_reg      <= 8'h00;
			map_reg        <= {DMC_RST_LARGE, 7'h00};
			ctl_reg        <= {DMC_RST_WAKE, DMC_RST_DELAY, DMC_RST_CTL_LOW};
			strap_pend_reg <= 1'b1;
			rd_reg         <= 8'h00;
		end else begin
			index_reg      <= index_next;
			map_reg        <= map_next;
			ctl_reg        <= ctl_next;
			strap_pend_reg <= strap_pend_next;
			rd_reg         <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode of map settings
	logic       remap_ok;
	logic       rom_hit_vid;
	logic       rom_hit_sys;
	logic [7:0] map_top_seg;
	logic       dec_vid_next;
	logic       dec_slot_next;
	logic       dec_rem_next;
	logic       dec_ok_next;
	logic [7:0] dec_seg_next;
	logic       dec_vid_reg;
	logic       dec_slot_reg;
	logic       dec_rem_reg;
	logic       dec_ok_reg;
	logic [7:0] dec_seg_reg;

	always_comb begin
		// Totals other than whole 1M to 4M cannot take the remap
		remap_ok    = (total_mem_mb >= 5'd1) && (total_mem_mb <= 5'd4);
		map_top_seg = 8'({total_mem_mb, 4'h0});
		rom_hit_vid = (addr_seg == DMC_VID_ROM_SEG);
		rom_hit_sys = (addr_seg == DMC_SYS_ROM_SEG);
		dec_ok_next   = map_reg[DMC_MAP_REMAP] && remap_ok;
		dec_vid_next  = rom_hit_vid && (map_reg[DMC_MAP_ROM_HI] || map_reg[DMC_MAP_ROM_LO]);
		dec_slot_next = rom_hit_sys && (map_reg[DMC_MAP_ROM_HI] || map_reg[DMC_MAP_ROM_LO]);
		// Remap window sits just above the top of installed memory (total_mem_mb)
		dec_rem_next  = dec_ok_next && (addr_seg >= map_top_seg)
			&& (addr_seg < 8'(map_top_seg + DMC_REMAP_SIZE));
		dec_seg_next  = dec_rem_next ? 8'(addr_seg - map_top_seg + DMC_REMAP_BASE) : addr_seg;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dec_vid_reg  <= 1'b0;
			dec_slot_reg <= 1'b0;
			dec_rem_reg  <= 1'b0;
			dec_ok_reg   <= 1'b0;
			dec_seg_reg  <= 8'h00;
		end else begin
			dec_vid_reg  <= dec_vid_next;
			dec_slot_reg <= dec_slot_next;
			dec_rem_reg  <= dec_rem_next;
			dec_ok_reg   <= dec_ok_next;
			dec_seg_reg  <= dec_seg_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared pin role and wake drive
	logic wake_role;
	logic pin_out_next;
	logic pin_oe_next;
	logic pin_out_reg;
	logic pin_oe_reg;

	always_comb begin
		// Wake role needs cache-enable clear; the logic gates it with cache_feature_on
		wake_role    = !cache_feature_on && ctl_reg[DMC_CTL_WAKE];
		pin_oe_next  = wake_role;
		// Active wake is high, pulled low through DMA and master cycles
		pin_out_next = wake_role && !dma_or_master;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_out_reg <= 1'b0;
			pin_oe_reg  <= 1'b0;
		end else begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg  <= pin_oe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Double-rate clock enable and cycle start delay
	logic [7:0] div_reg;
	logic [7:0] div_next;
	logic       tick_reg;
	logic       tick_next;

	always_comb begin
		tick_next = (div_reg == 8'(CLK_DIV - 1));
		div_next  = tick_next ? 8'h00 : 8'(div_reg + 8'h01);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_reg  <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	dmc_start_delay u_start (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.dbl_clk_en    (tick_reg),
		.delay_on      (ctl_reg[DMC_CTL_DELAY]),
		.mem_read_miss (mem_read_miss),
		.strobe_rise   (addr_strobe_rise),
		.cycle_start   (cycle_start)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rd_data           = rd_reg;
	assign large_bank_option = map_reg[DMC_MAP_LARGE];
	assign memory_map_code   = map_reg[DMC_MAP_CODE_LSB +: DMC_MAP_CODE_W];
	assign remap_active      = dec_ok_reg;
	assign rom_on_board      = dec_vid_reg;
	assign rom_to_slot       = dec_slot_reg;
	assign remap_hit         = dec_rem_reg;
	assign remap_seg         = dec_seg_reg;
	assign wake_out          = pin_out_reg;
	assign wake_oe           = pin_oe_reg;
endmodule

// [verification/dmc_map_checker.sv]
// Checker: port timing of the DRAM map registers
`timescale 1ns/1ps
module dmc_map_checker
	import dmc_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// Port access
	input wire logic       idx_wr,
	input wire logic       data_wr,
	input wire logic       data_rd,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	// Inputs and outputs watched
	input wire logic       cache_feature_set,
	input wire logic [4:0] total_mem_mb,
	input wire logic       dma_or_master,
	input wire logic       large_bank_option,
	input wire logic [3:0] memory_map_code,
	input wire logic       remap_active,
	input wire logic       wake_out,
	input wire logic       wake_oe,
	input wire logic       cycle_start
);
	logic [7:0] idx_reg;
	logic [7:0] idx_next;
	logic       map_sel;
	////////////////////////////////////////////////////////////////
	always_comb begin
		idx_next = idx_wr ? wr_data : idx_reg;
		map_sel = !idx_wr && idx_reg == DMC_IDX_MAP;
	end
	always_ff @(posedge clk_sys) begin
		idx_reg <= rst ? 8'h00 : idx_next;
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	map_read_a: assert property (data_rd && !data_wr && map_sel |=>
		rd_data[3:0] == $past(memory_map_code) && rd_data[7] == $past(large_bank_option)) else $error("map read");
	map_write_a: assert property (data_wr && map_sel |=>
		memory_map_code == $past(wr_data[3:0]) && large_bank_option == $past(wr_data[7])) else $error("map write");
	unmap_read_a: assert property (data_rd && !idx_wr && idx_reg != DMC_IDX_MAP && idx_reg != DMC_IDX_CTRL
		|=> rd_data == 8'h00) else $error("unmapped read");
	read_hold_a: assert property (!data_rd |=> $stable(rd_data)) else $error("read data moved");
	reset_clear_a: assert property (disable iff (1'b0) rst |=>
		rd_data == 8'h00 && !wake_oe && !cycle_start && !remap_active) else $error("reset value");
	remap_total_a: assert property (remap_active |->
		$past(total_mem_mb) >= 5'd1 && $past(total_mem_mb) <= 5'd4) else $error("remap total");
	wake_clear_a: assert property (cache_feature_set |-> ##[1:2] !wake_oe) else $error("wake not cleared");
	dma_low_a: assert property (dma_or_master |=> !wake_out || !wake_oe) else $error("wake high in dma");
	cover property (cycle_start);
	cover property (remap_active);
	cover property (wake_oe && !wake_out);
endmodule

// [verification/dmc_host_model.sv]
// Host model: drives the index and data ports
`timescale 1ns/1ps
module dmc_host_model (
	// Clock
	input wire logic       clk_sys,
	// Port access
	output logic           idx_wr,
	output logic           data_wr,
	output logic           data_rd,
	output logic     [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	initial begin
		{idx_wr, data_wr, data_rd} = 3'h0;
		wr_data = 8'h00;
	end
	// Index, then one data cycle; released data shows the inverse so stale values never match
	task automatic xfer(input logic [7:0] idx, input logic [7:0] val, input logic rd);
		@(posedge clk_sys);
		#1;
		idx_wr = 1'b1;
		wr_data = idx;
		@(posedge clk_sys);
		#1;
		idx_wr = 1'b0;
		data_wr = !rd;
		data_rd = rd;
		wr_data = val;
		@(posedge clk_sys);
		#1;
		{data_wr, data_rd} = 2'h0;
		wr_data = ~val;
	endtask
endmodule

// [verification/dmc_dram_map_regs_bench.sv]
// Testbench: register access, straps, decode, wake pin and start delay
`timescale 1ns/1ps
module dmc_dram_map_regs_bench;
	import dmc_pkg::*;
	localparam int DIV = 2;
	logic       clk_sys = 1'b0;
	logic       rst, s8, s7, s4, c_on, c_set, dma, asr, miss;
	logic       idx_wr, data_wr, data_rd, rob, rts, rhit, lbo, ract, wo, woe, cs;
	logic [3:0] slow, mmc;
	logic [4:0] tot;
	logic [7:0] wr_data, rd_data, seg, rseg, v;
	int         error_cnt = 0;
	int         samples_checked = 0;
	int         n0, n1, n2;
	logic       sleep_lvl = 1'b0;
	logic       sleep_comb;
	// Board glue: wake is ORed with the sleep line toward the cache unit
	assign sleep_comb = wo | sleep_lvl;
	always #2 clk_sys = ~clk_sys;
	dmc_host_model dmc_host_model_i (.clk_sys(clk_sys), .idx_wr(idx_wr), .data_wr(data_wr), .data_rd(data_rd),
		.wr_data(wr_data), .rd_data(rd_data));
	dmc_dram_map_regs #(.CLK_DIV(DIV)) dmc_dram_map_regs_i (.clk_sys(clk_sys), .rst(rst), .strap_line_8(s8),
		.strap_line_7(s7), .strap_line_4(s4), .strap_lines_low(slow), .idx_wr(idx_wr), .data_wr(data_wr),
		.data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data), .cache_feature_on(c_on), .cache_feature_set(c_set),
		.total_mem_mb(tot), .dma_or_master(dma), .addr_strobe_rise(asr), .mem_read_miss(miss), .addr_seg(seg),
		.rom_on_board(rob), .rom_to_slot(rts), .remap_seg(rseg), .remap_hit(rhit), .large_bank_option(lbo),
		.memory_map_code(mmc), .remap_active(ract), .wake_out(wo), .wake_oe(woe), .cycle_start(cs));
	////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compares %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		dmc_host_model_i.xfer(idx, 8'h00, 1'b1);
		check(rd_data, exp);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		dmc_host_model_i.xfer(idx, val, 1'b0);
	endtask
	// Counts cycles from strobe to start pulse; a lost pulse ends the run
	task automatic time_start(output int n);
		asr = 1'b1;
		step(1);
		asr = 1'b0;
		n = 0;
		while (cs !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		if (n == 20) begin
			error_cnt++;
			complete_run();
		end
		step(1);
	endtask
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rst, s8, s7, s4, slow} = 8'hda;
		{c_on, c_set, dma, asr, miss} = 5'h00;
		tot = 5'd2;
		seg = 8'h00;
		step(3);
		rst = 1'b0;
		rd(DMC_IDX_MAP, 8'h5a);
		check({4'h0, mmc}, 8'h0a);
		rd(DMC_IDX_CTRL, 8'h00);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h00);
		rd(DMC_IDX_MAP, 8'h5a);
		wr(DMC_IDX_MAP, 8'h93);
		rd(DMC_IDX_MAP, 8'h93);
		check({7'h0, lbo}, 8'h01);
		for (int i = 0; i < 7; i++) begin
			tot = i[4:0];
			step(2);
			check({7'h0, ract}, {7'h0, i >= 1 && i <= 4});
		end
		tot = 5'd2;
		seg = 8'h21;
		step(2);
		check(rseg, 8'h0b);
		check({7'h0, rhit}, 8'h01);
		seg = 8'h26;
		step(2);
		check({7'h0, rhit}, 8'h00);
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1 ? 8'h40 : 8'h20);
			wr(DMC_IDX_MAP, v);
			seg = DMC_VID_ROM_SEG;
			step(2);
			check({7'h0, rob}, {7'h0, k != 0});
			seg = DMC_SYS_ROM_SEG;
			step(2);
			check({7'h0, rts}, {7'h0, k != 0});
		end
		wr(DMC_IDX_CTRL, 8'h80);
		step(2);
		check({6'h0, woe, wo}, 8'h03);
		check({7'h0, sleep_comb}, 8'h01);
		dma = 1'b1;
		step(2);
		check({6'h0, woe, wo}, 8'h02);
		check({7'h0, sleep_comb}, 8'h00);
		dma = 1'b0;
		{c_on, c_set} = 2'h3;
		step(1);
		c_set = 1'b0;
		step(2);
		check({7'h0, woe}, 8'h00);
		rd(DMC_IDX_CTRL, 8'h00);
		c_on = 1'b0;
		miss = 1'b1;
		time_start(n0);
		wr(DMC_IDX_CTRL, 8'h40);
		rd(DMC_IDX_CTRL, 8'h40);
		time_start(n1);
		check({7'h0, n1 >= n0 + DIV && n1 <= n0 + 2 * DIV + 1}, 8'h01);
		miss = 1'b0;
		time_start(n2);
		check({7'h0, n2 == n0}, 8'h01);
		complete_run();
	end
endmodule
bind dmc_dram_map_regs dmc_map_checker dmc_map_checker_i (.clk_sys(clk_sys), .rst(rst), .idx_wr(idx_wr),
	.data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data), .cache_feature_set(cache_feature_set),
	.total_mem_mb(total_mem_mb), .dma_or_master(dma_or_master), .large_bank_option(large_bank_option),
	.memory_map_code(memory_map_code), .remap_active(remap_active), .wake_out(wake_out), .wake_oe(wake_oe),
	.cycle_start(cycle_start));
